// ### hw/pmbus_pkg.sv
package pmbus_pkg;

  // command codes understood by the decoder
  localparam logic [7:0] CMD_CONTROL = 8'h01;
  localparam logic [7:0] CMD_ENCFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_WP = 8'h10;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_RESTORE = 8'h12;
  localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
  localparam logic [7:0] CMD_STAT_WORD = 8'h79;
  localparam logic [7:0] CMD_MFR_BASE = 8'hD0;
  localparam logic [2:0] MFR_LAST = 3'h6;

  // target address is prefix followed by the four strap bits
  localparam logic [2:0] ADDR_PREFIX = 3'h1;

  // field positions
  localparam int CTL_ON_BIT = 7;
  localparam int CTL_MARGIN_LSB = 2;
  localparam logic [7:0] CFG_ONES = 8'h13;

  // write-protect levels
  localparam logic [7:0] WP_ALL = 8'h80;
  localparam logic [7:0] WP_CTL = 8'h40;
  localparam logic [7:0] WP_CFG = 8'h20;
  localparam logic [7:0] WP_NONE = 8'h00;

  // reset values; source select is {command, pin}
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [1:0] SRC_RST = 2'h1;
  localparam logic [7:0] WP_RST = 8'h00;
  localparam logic [7:0] MFR_RST = 8'h00;

  // synchroniser lane map
  localparam int SYNC_W = 13;
  localparam int SI_SCL = 0;
  localparam int SI_SDA = 1;
  localparam int SI_EN = 2;
  localparam int SI_ADONE = 3;
  localparam int SI_OV = 4;
  localparam int SI_OC = 5;
  localparam int SI_UV = 6;
  localparam int SI_OT = 7;
  localparam int SI_PG = 8;
  localparam int SI_ADDR = 9;
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0003;

  typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_RACK} bus_st_t;
  typedef enum logic [2:0] {MARGIN_OFF, MARGIN_LOW_IGN, MARGIN_LOW_ACT, MARGIN_HIGH_IGN, MARGIN_HIGH_ACT} margin_t;

endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [pmbus_pkg::SYNC_W-1:0] pins_in,
  output logic [pmbus_pkg::SYNC_W-1:0] pins_out
);
  import pmbus_pkg::*;

  // three stages plus the accepted level per lane
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
  } sync_st_t;

  sync_st_t s;
  sync_st_t n;

  ////////////////////////////////////////////////////////////////////////////
  // next state: a lane changes only once stage two and three agree
  always_comb begin
    n = s;
    n.s1 = pins_in;
    // first stage feeds the second and nothing else
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        n.filt[i] = s.s3[i];
      end
    end
  end

  // bus lines idle high, so they reset high to avoid a false start
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, filt: SYNC_RST};
    end else begin
      s <= n;
    end
  end

  assign pins_out = s.filt;

endmodule // pin_sync

// ### hw/pmbus_command_handler.sv
`timescale 1ns/1ps
// Function
// - clear, store, restore carry no data
// - unsupported codes acked, then discarded
// - unsupported code sets comms fault, alert
// - control byte read/write, bit7 on/off
// - unused control and config bits ignored
// - margin field decodes off/low/high modes
// - config bits 4,1,0 always read one
// - config source selects, default pin only
// - pin-only source follows enable pin
// - command-only source follows on/off bit
// - both sources enable by logical AND
// - no source enables after address detection
// - write-protect byte stored and readable
// - protect level gates writes per table
// - zero allows all, others are fault
// - store copies registers to nonvolatile cells
// - restore copies nonvolatile cells to registers
// - clear command clears latched status flags
// - seven manufacturer byte registers D0..D6
// - source selects backed by nonvolatile cells
// - clear releases alert, persisting faults stay set
// - comms fault flag is latched
// - read returns byte addressed by command
module pmbus_command_handler (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_out,
  output logic alert_oe,
  input wire logic en_pin,
  input wire logic addr_done,
  input wire logic [3:0] addr_pins,
  input wire logic fault_ov,
  input wire logic fault_oc,
  input wire logic fault_uv,
  input wire logic fault_ot,
  input wire logic pgood_pin,
  output logic converter_enable,
  output pmbus_pkg::margin_t margin_mode,
  output logic [55:0] mfr_settings
);
  import pmbus_pkg::*;

  // whole block state; nonvolatile cells are modelled by flops
  typedef struct packed {
    bus_st_t st;          // bit-level target state
    logic [3:0] bitcnt;   // bits moved in the current byte
    logic [7:0] sh;       // shift register
    logic rw;             // direction from the address byte
    logic [1:0] byte_cnt; // byte index in the frame, saturates
    logic [7:0] cmd;      // command pointer, kept across frames
    logic rd_idx;         // byte index for word reads
    logic master_ack;     // host acked the last read byte
    logic sda_oe;         // pulling data low
    logic scl_prev;       // for edge detection
    logic sda_prev;
    logic [7:0] ctl;      // converter control byte
    logic [1:0] src;      // {command source, pin source}
    logic [7:0] wp;       // write-protect level
    logic [6:0][7:0] mfr; // manufacturer registers
    logic [1:0] nvm_src;  // stored source selects
    logic [6:0][7:0] nvm_mfr;
    logic f_ov;           // latched fault flags
    logic f_oc;
    logic f_uv;
    logic f_ot;
    logic f_cml;
    logic en_out;
    margin_t margin;
    logic alert;
  } state_t;

  state_t s;
  state_t n;
  logic [SYNC_W-1:0] pins_f; // filtered pin levels
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic cmd_phase;  // command byte complete this cycle
  logic data_phase; // first data byte complete this cycle

  ////////////////////////////////////////////////////////////////////////////
  // every outside level goes through the three-stage filter
  pin_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pins_in({addr_pins, pgood_pin, fault_ot, fault_uv, fault_oc, fault_ov, addr_done, en_pin, sda_in, scl_in}),
    .pins_out(pins_f)
  );

  assign scl_f = pins_f[SI_SCL];
  assign sda_f = pins_f[SI_SDA];
  assign scl_rise = scl_f & ~s.scl_prev;
  assign scl_fall = ~scl_f & s.scl_prev;
  // start and stop are data edges while the clock is high
  assign start_c = s.scl_prev & scl_f & s.sda_prev & ~sda_f;
  assign stop_c = s.scl_prev & scl_f & ~s.sda_prev & sda_f;
  assign cmd_phase = (s.st == BUS_RX) && scl_fall && (s.bitcnt == 4'h8) && (s.byte_cnt == 2'h1);
  assign data_phase = (s.st == BUS_RX) && scl_fall && (s.bitcnt == 4'h8) && (s.byte_cnt == 2'h2);

  ////////////////////////////////////////////////////////////////////////////
  // command decoding helpers

  // manufacturer register window
  function automatic logic is_mfr(input logic [7:0] c);
    return (c[7:3] == CMD_MFR_BASE[7:3]) && (c[2:0] <= MFR_LAST);
  endfunction

  // codes that take one data byte on write
  function automatic logic is_writable(input logic [7:0] c);
    return (c == CMD_CONTROL) || (c == CMD_ENCFG) || (c == CMD_WP) || is_mfr(c);
  endfunction

  function automatic logic is_supported(input logic [7:0] c);
    return is_writable(c) || (c == CMD_CLEAR) || (c == CMD_STORE) || (c == CMD_RESTORE)
           || (c == CMD_STAT_BYTE) || (c == CMD_STAT_WORD);
  endfunction

  // protect level decides which codes may change state
  function automatic logic write_allowed(input logic [7:0] c, input logic [7:0] wp);
    logic ok;
    ok = 1'b0;
    if (c == CMD_WP) begin
      ok = 1'b1;
    end else if (wp == WP_NONE) begin
      ok = 1'b1;
    end else if (c == CMD_CONTROL) begin
      ok = (wp == WP_CTL) || (wp == WP_CFG);
    end else if (c == CMD_ENCFG) begin
      ok = (wp == WP_CFG);
    end
    return ok;
  endfunction

  // margin field; undefined codes leave margining off
  function automatic margin_t margin_decode(input logic [3:0] f);
    margin_t m;
    unique case (f)
      4'h5: m = MARGIN_LOW_IGN;
      4'h6: m = MARGIN_LOW_ACT;
      4'h9: m = MARGIN_HIGH_IGN;
      4'hA: m = MARGIN_HIGH_ACT;
      default: m = MARGIN_OFF;
    endcase
    return m;
  endfunction

  // byte returned for a read of command c
  function automatic logic [7:0] rd_byte(input state_t st, input logic [7:0] c, input logic idx,
                                         input logic pg);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] r;
    // status low: off, ov, oc, uv, temp, comms; busy and other read zero
    lo = {1'h0, ~st.en_out, st.f_ov, st.f_oc, st.f_uv, st.f_ot, st.f_cml, 1'h0};
    // status high: vout, iout, input groups and raw power-good low
    hi = {st.f_ov, st.f_oc, st.f_uv, 1'h0, ~pg, 3'h0};
    r = 8'hFF;
    if (c == CMD_CONTROL) begin
      r = st.ctl;
    end else if (c == CMD_ENCFG) begin
      r = CFG_ONES | {4'h0, st.src, 2'h0};
    end else if (c == CMD_WP) begin
      r = st.wp;
    end else if (c == CMD_STAT_BYTE) begin
      r = lo;
    end else if (c == CMD_STAT_WORD) begin
      r = idx ? hi : lo;
    end else if (is_mfr(c)) begin
      r = st.mfr[c[2:0]];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus target, command execution, enables and flags
  always_comb begin
    logic clr;
    logic cml_set;
    logic [7:0] rd;
    clr = 1'b0;
    cml_set = 1'b0;
    rd = 8'h00;
    n = s;
    n.scl_prev = scl_f;
    n.sda_prev = sda_f;

    if (stop_c) begin
      // stop ends any frame; pointer in cmd survives for later reads
      n.st = BUS_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      // start and repeated start both begin with an address byte
      n.st = BUS_RX;
      n.bitcnt = 4'h0;
      n.byte_cnt = 2'h0;
      n.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        BUS_IDLE: begin
          n.sda_oe = 1'b0;
        end
        BUS_RX: begin
          if (scl_rise && (s.bitcnt != 4'h8)) begin
            n.sh = {s.sh[6:0], sda_f};
            n.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall && (s.bitcnt == 4'h8)) begin
            // a full byte: acknowledge it on this falling edge
            n.st = BUS_ACK;
            n.sda_oe = 1'b1;
            if (s.byte_cnt == 2'h0) begin
              n.rw = s.sh[0];
              if (s.sh[7:1] != {ADDR_PREFIX, pins_f[SI_ADDR +: 4]}) begin
                // another target: stay off the bus until next start
                n.st = BUS_IDLE;
                n.sda_oe = 1'b0;
              end
            end else if (s.byte_cnt == 2'h1) begin
              // command byte: acked even when unknown
              n.cmd = s.sh;
              n.rd_idx = 1'b0;
              if (!is_supported(s.sh)) begin
                cml_set = 1'b1;
              end else if (s.sh == CMD_CLEAR) begin
                clr = 1'b1;
              end else if ((s.sh == CMD_STORE) && write_allowed(s.sh, s.wp)) begin
                n.nvm_src = s.src;
                n.nvm_mfr = s.mfr;
              end else if ((s.sh == CMD_RESTORE) && write_allowed(s.sh, s.wp)) begin
                n.src = s.nvm_src;
                n.mfr = s.nvm_mfr;
              end
            end else if ((s.byte_cnt == 2'h2) && is_writable(s.cmd)) begin
              // one data byte; a protected write is acked and dropped
              if (write_allowed(s.cmd, s.wp)) begin
                if (s.cmd == CMD_CONTROL) begin
                  n.ctl = s.sh;
                end else if (s.cmd == CMD_ENCFG) begin
                  n.src = s.sh[3:2];
                end else if (s.cmd == CMD_WP) begin
                  if ((s.sh == WP_ALL) || (s.sh == WP_CTL) || (s.sh == WP_CFG) || (s.sh == WP_NONE)) begin
                    n.wp = s.sh;
                  end else begin
                    cml_set = 1'b1;
                  end
                end else begin
                  n.mfr[s.cmd[2:0]] = s.sh;
                end
              end
            end else begin
              // data after a send-byte, a read-only code or a surplus byte
              cml_set = 1'b1;
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            n.bitcnt = 4'h0;
            if (s.byte_cnt != 2'h3) begin
              n.byte_cnt = s.byte_cnt + 2'h1;
            end
            if (s.rw) begin
              // read: present the byte chosen by the stored pointer
              rd = rd_byte(s, s.cmd, s.rd_idx, pins_f[SI_PG]);
              n.st = BUS_TX;
              n.sh = rd;
              n.sda_oe = ~rd[7];
            end else begin
              n.st = BUS_RX;
              n.sda_oe = 1'b0;
            end
          end
        end
        BUS_TX: begin
          if (scl_rise) begin
            n.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall) begin
            if (s.bitcnt == 4'h8) begin
              // release data so the host can ack or nack
              n.st = BUS_RACK;
              n.sda_oe = 1'b0;
            end else begin
              n.sh = {s.sh[6:0], 1'b0};
              n.sda_oe = ~s.sh[6];
            end
          end
        end
        BUS_RACK: begin
          if (scl_rise) begin
            n.master_ack = ~sda_f;
          end
          if (scl_fall) begin
            if (s.master_ack) begin
              // host wants more: second byte of a word, else repeat
              rd = rd_byte(s, s.cmd, 1'b1, pins_f[SI_PG]);
              n.rd_idx = 1'b1;
              n.st = BUS_TX;
              n.bitcnt = 4'h0;
              n.sh = rd;
              n.sda_oe = ~rd[7];
            end else begin
              // nack ends the read; wait for stop
              n.st = BUS_IDLE;
            end
          end
        end
        default: begin
          n.st = BUS_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // latched flags: a live condition wins over a clear in the same cycle
    n.f_ov = (s.f_ov & ~clr) | pins_f[SI_OV];
    n.f_oc = (s.f_oc & ~clr) | pins_f[SI_OC];
    n.f_uv = (s.f_uv & ~clr) | pins_f[SI_UV];
    n.f_ot = (s.f_ot & ~clr) | pins_f[SI_OT];
    n.f_cml = (s.f_cml & ~clr) | cml_set;
    n.alert = s.f_ov | s.f_oc | s.f_uv | s.f_ot | s.f_cml;

    // enable source selection
    unique case (s.src)
      2'h1: n.en_out = pins_f[SI_EN];
      2'h2: n.en_out = s.ctl[CTL_ON_BIT];
      2'h3: n.en_out = s.ctl[CTL_ON_BIT] & pins_f[SI_EN];
      2'h0: n.en_out = pins_f[SI_ADONE];
    endcase
    n.margin = margin_decode(s.ctl[CTL_MARGIN_LSB +: 4]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; power-on loads factory values into both copies
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{st: BUS_IDLE, bitcnt: 4'h0, sh: 8'h00, rw: 1'b0, byte_cnt: 2'h0, cmd: 8'h00, rd_idx: 1'b0,
             master_ack: 1'b0, sda_oe: 1'b0, scl_prev: 1'b1, sda_prev: 1'b1, ctl: CTL_RST,
             src: SRC_RST, wp: WP_RST, mfr: {7{MFR_RST}}, nvm_src: SRC_RST, nvm_mfr: {7{MFR_RST}},
             f_ov: 1'b0, f_oc: 1'b0, f_uv: 1'b0, f_ot: 1'b0, f_cml: 1'b0, en_out: 1'b0,
             margin: MARGIN_OFF, alert: 1'b0};
    end else begin
      s <= n;
    end
  end

  // open-drain pins only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = s.sda_oe;
  assign alert_out = 1'b0;
  assign alert_oe = s.alert;
  assign converter_enable = s.en_out;
  assign margin_mode = s.margin;
  assign mfr_settings = s.mfr;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pin_only_src: assert property ((s.src == 2'h1) |=> (s.en_out == $past(pins_f[SI_EN])))
    else $error("pin-only source did not follow the enable pin");
  a_cmd_only_src: assert property ((s.src == 2'h2) |=> (s.en_out == $past(s.ctl[CTL_ON_BIT])))
    else $error("command-only source did not follow the on/off bit");
  a_both_src_and: assert property ((s.src == 2'h3) && !s.ctl[CTL_ON_BIT] |=> !s.en_out)
    else $error("enable with on/off bit low under both sources");
  a_auto_src_done: assert property ((s.src == 2'h0) && pins_f[SI_ADONE] |=> s.en_out)
    else $error("no enable after address detection");
  a_margin_low_act: assert property ((s.ctl[5:2] == 4'h6) |=> (s.margin == MARGIN_LOW_ACT))
    else $error("margin low act-on-fault not decoded");
  a_cfg_read_ones: assert property (s.st == BUS_ACK && s.rw && scl_fall && s.cmd == CMD_ENCFG && !stop_c
                                    && !start_c |=> (s.sh[4] && s.sh[1] && s.sh[0]))
    else $error("config read lost forced ones");
  a_wp_blocks_ctl: assert property (data_phase && s.cmd == CMD_CONTROL && s.wp == WP_ALL && !stop_c
                                    |=> s.ctl == $past(s.ctl))
    else $error("protected control write took effect");
  a_unsup_cml: assert property (cmd_phase && !stop_c && !start_c && !is_supported(s.sh)
                                |=> s.f_cml ##1 alert_oe)
    else $error("unsupported code did not raise fault and alert");
  a_clear_drops_ov: assert property (cmd_phase && !stop_c && !start_c && s.sh == CMD_CLEAR
                                     && !pins_f[SI_OV] |=> !s.f_ov)
    else $error("clear did not drop overvoltage flag");
  a_store_copies: assert property (cmd_phase && !stop_c && !start_c && s.sh == CMD_STORE && s.wp == WP_NONE
                                   |=> s.nvm_mfr == $past(s.mfr))
    else $error("store did not copy registers");

endmodule // pmbus_command_handler

// ### tb/pmbus_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus host model: owns the clock line, pulls data low; one bit is 8 system clocks
module pmbus_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // lines idle released (pulled high)
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one step is two system clocks; all changes land just after a rising edge
  task automatic q(input int n);
    repeat (2 * n) @(posedge clk);
  endtask
  // start or repeated start; waits first so a held device ack has gone
  task automatic start();
    sda_low <= 1'b0;
    q(4);
    scl <= 1'b1;
    q(2);
    sda_low <= 1'b1;
    q(2);
    scl <= 1'b0;
    q(1);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_low <= 1'b1;
    q(1);
    scl <= 1'b1;
    q(2);
    sda_low <= 1'b0;
    q(2);
  endtask
  // long low phase: the device answers about five clocks after it sees a fall, and that
  // change must clear the pin filters before the clock rises, or it reads as start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    q(2);
    scl <= 1'b1;
    q(1);
    r = sda;
    scl <= 1'b0;
    q(1);
  endtask
  // byte to device, msb first; caller picks the code
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // byte from device, then our ack or nack
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule  // pmbus_host

// ### tb/pmbus_command_handler_tb.sv
`timescale 1ns/1ps
module pmbus_command_handler_tb;
  import pmbus_pkg::*;
  logic clk, rst_b, en_pin, addr_done, fault_ov, scl, sda_low, sda_oe, alert_oe, converter_enable;
  logic [3:0] addr_pins;
  margin_t margin_mode;
  logic [55:0] mfr_settings;
  // open-drain data line with pull-up
  wire sda = ~(sda_low | sda_oe);
  int n_errors, checks_done, ctl, src, wp, nsrc, ov, cml, seed;
  int mfr[7], nmfr[7];
  int regs[12] = '{8'h01, 8'h02, 8'h10, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'h78, 8'h79};
  int lv[4] = '{8'h80, 8'h40, 8'h20, 8'h00};
  pmbus_command_handler pmbus_command_handler_inst (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .alert_out(), .alert_oe(alert_oe), .en_pin(en_pin), .addr_done(addr_done),
    .addr_pins(addr_pins), .fault_ov(fault_ov), .fault_oc(1'b0), .fault_uv(1'b0), .fault_ot(1'b0),
    .pgood_pin(1'b1), .converter_enable(converter_enable), .margin_mode(margin_mode),
    .mfr_settings(mfr_settings));
  pmbus_host pmbus_host_inst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////////////
  // compares
  task automatic chk_byte(input logic [7:0] got, input int exp);
    checks_done++;
    if (got !== 8'(exp)) begin
      n_errors++;
      $display("ERROR t=%0t byte got %h exp %h", $time, got, 8'(exp));
    end
  endtask
  task automatic chk_bit(input logic got, input int exp);
    checks_done++;
    if (got !== 1'(exp)) begin
      n_errors++;
      $display("ERROR t=%0t bit got %b exp %b", $time, got, 1'(exp));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic bit may_write(int c);
    if (c == 8'h10) return 1'b1;
    if (wp == 8'h40) return c == 8'h01;
    if (wp == 8'h20) return c inside {8'h01, 8'h02};
    return wp == 8'h00;
  endfunction
  function automatic bit en_exp();
    case (src)
      1: return en_pin;
      2: return ctl[7];
      3: return en_pin & ctl[7];
      default: return addr_done;
    endcase
  endfunction
  // undefined margin codes read as off
  function automatic int m_exp();
    case (ctl[5:2])
      4'h5: return MARGIN_LOW_IGN;
      4'h6: return MARGIN_LOW_ACT;
      4'h9: return MARGIN_HIGH_IGN;
      4'hA: return MARGIN_HIGH_ACT;
      default: return MARGIN_OFF;
    endcase
  endfunction
  function automatic int exp_rd(int c);
    if (c == 8'h01) return ctl;
    if (c == 8'h02) return 8'h13 | (src << 2);
    if (c == 8'h10) return wp;
    // status low byte: bit6 converter off, bit5 overvoltage, bit1 comms fault
    if (c inside {8'h78, 8'h79}) return (en_exp() ? 0 : 8'h40) | (ov << 5) | (cml << 1);
    return mfr[c - 8'hD0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // frames; every byte must be acknowledged, even refused ones
  task automatic wr(input int c, input int d, input bit hd);
    logic a0, a1, a2;
    a2 = 1'b1;
    pmbus_host_inst.start();
    pmbus_host_inst.send({3'b001, addr_pins, 1'b0}, a0);
    pmbus_host_inst.send(8'(c), a1);
    if (hd) pmbus_host_inst.send(8'(d), a2);
    pmbus_host_inst.stop();
    chk_bit(a0 & a1 & a2, 1);
    if (!hd) begin
      if (c == 8'h03) begin
        cml = 0;
        ov = fault_ov;
      end else if (may_write(c) && c == 8'h11) begin
        nsrc = src;
        nmfr = mfr;
      end else if (may_write(c) && c == 8'h12) begin
        src = nsrc;
        mfr = nmfr;
      end
    end else if (c == 8'h10) begin
      if (d inside {8'h00, 8'h20, 8'h40, 8'h80}) wp = d;
      else cml = 1;
    end else if (!(c inside {8'h01, 8'h02, [8'hD0:8'hD6]})) cml = 1;
    else if (may_write(c)) begin
      if (c == 8'h01) ctl = d;
      else if (c == 8'h02) src = (d >> 2) & 3;
      else mfr[c - 8'hD0] = d;
    end
  endtask
  task automatic rd(input int c);
    logic a0, a1, a2;
    logic [7:0] d;
    logic [7:0] h;
    h = 8'h00;
    pmbus_host_inst.start();
    pmbus_host_inst.send({3'b001, addr_pins, 1'b0}, a0);
    pmbus_host_inst.send(8'(c), a1);
    pmbus_host_inst.start();
    pmbus_host_inst.send({3'b001, addr_pins, 1'b1}, a2);
    // status word: ack the low byte, nack the high byte
    pmbus_host_inst.recv(c != 8'h79, d);
    if (c == 8'h79) pmbus_host_inst.recv(1'b1, h);
    pmbus_host_inst.stop();
    chk_bit(a0 & a1 & a2, 1);
    chk_byte(d, exp_rd(c));
    if (c == 8'h79) chk_byte(h, ov << 7);
  endtask
  // outputs after the pin filters have settled
  task automatic outs();
    repeat (12) @(posedge clk);
    chk_bit(converter_enable, en_exp());
    chk_byte(8'(margin_mode), m_exp());
    chk_bit(alert_oe, cml | ov);
    for (int k = 0; k < 7; k++) chk_byte(mfr_settings[8*k +: 8], mfr[k]);
  endtask
  task automatic all_regs();
    foreach (regs[k]) rd(regs[k]);
    outs();
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog near 96k clocks, well beyond the expected run of about 70k
  initial begin
    #2400000;
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    en_pin = 1'b1;
    addr_done = 1'b1;
    fault_ov = 1'b0;
    addr_pins = 4'hA;
    {ctl, wp, ov, cml} = '0;
    src = 1;
    nsrc = 1;
    mfr = '{default: 0};
    nmfr = mfr;
    seed = $urandom(32'hE7CF);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    all_regs();
    $display("test reset values done");
    for (int m = 0; m < 16; m++) begin
      wr(8'h01, ($urandom & 8'hC3) | (m << 2), 1);
      rd(8'h01);
      outs();
    end
    $display("test margin done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h02, ($urandom & 8'hF3) | (s << 2), 1);
      rd(8'h02);
      for (int v = 0; v < 8; v++) begin
        wr(8'h01, v[1] << 7, 1);
        en_pin <= v[0];
        addr_done <= v[2];
        outs();
      end
    end
    addr_done <= 1'b1;
    $display("test enable sources done");
    for (int k = 0; k < 7; k++) wr(8'hD0 + k, $urandom & 8'hFF, 1);
    all_regs();
    foreach (lv[i]) begin
      wr(8'h10, lv[i], 1);
      wr(8'h01, $urandom & 8'hFF, 1);
      wr(8'h02, $urandom & 8'hFF, 1);
      wr(8'hD3, $urandom & 8'hFF, 1);
      all_regs();
    end
    wr(8'h10, 8'h01, 1);
    all_regs();
    wr(8'h03, 0, 0);
    outs();
    wr(8'h55, $urandom & 8'hFF, 1);
    repeat (100) @(posedge clk);
    all_regs();
    wr(8'h03, 0, 0);
    $display("test protect and unsupported done");
    wr(8'h02, 8'h08, 1);
    wr(8'hD5, 8'h5A, 1);
    wr(8'h11, 0, 0);
    wr(8'h02, 8'h04, 1);
    wr(8'hD5, 8'hA5, 1);
    all_regs();
    wr(8'h12, 0, 0);
    all_regs();
    $display("test store restore done");
    fault_ov <= 1'b1;
    ov = 1;
    repeat (10) @(posedge clk);
    fault_ov <= 1'b0;
    outs();
    rd(8'h79);
    fault_ov <= 1'b1;
    wr(8'h03, 0, 0);
    outs();
    fault_ov <= 1'b0;
    wr(8'h03, 0, 0);
    outs();
    $display("test fault clear done");
    close_out();
  end
endmodule  // pmbus_command_handler_tb
